/* dv/msrc_ctrl_model.sv */
// Controller partner model: run, select and panel switch pins
`timescale 1ns/1ps
module msrc_ctrl_model (
  input  wire logic       aclk,
  input  wire logic       run_sw,       // Wanted panel switch, 1 = run
  input  wire logic       dir_sw,       // Wanted direction, 1 = reverse
  input  wire logic       forward_run_input,          // Wanted forward run
  input  wire logic       reverse_run_input,          // Wanted reverse run
  input  wire logic [1:0] sel,          // Wanted data set
  input  wire logic       remap,        // Forward run moved to pin 4
  output logic      [4:0] in_pins,      // Mapped input pins
  output logic            panel_run_sw, // Panel run switch
  output logic            panel_dir_sw  // Panel direction switch
);
  // Idle levels before the first edge
  initial begin
    in_pins = 5'h00;
    panel_run_sw = 1'b0;
    panel_dir_sw = 1'b0;
  end
  // Panel switches register on the rising edge, as the pins do
  always @(posedge aclk) begin
    panel_run_sw <= run_sw;
    panel_dir_sw <= dir_sw;
  end
  // Run pins register on the same edge as the switches; the bench sets the switch an edge before a run input rises
  always @(posedge aclk) begin
    in_pins <= {remap & forward_run_input, sel, reverse_run_input, ~remap & forward_run_input};
  end
endmodule

/* dv/multi_speed_run_control_test.sv */
// Self-checking bench for the multi-speed run control block
`timescale 1ns/1ps
`include "msrc_defs.svh"
module multi_speed_run_control_test;
  localparam int DB = 4;               // Short debounce for simulation
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;         // Bus addresses
  logic [31:0] wdata;                  // Write data
  logic [3:0]  wstrb;                  // Always full words
  wire  logic  awready, wready, bvalid, arready, rvalid, motor_dir, motor_on;
  wire  logic [1:0]  bresp, rresp, out_pins;
  wire  logic [31:0] rdata;
  wire  logic [15:0] speed_cmd;
  wire  logic [4:0]  in_pins;
  wire  logic        panel_run_sw, panel_dir_sw;
  logic        run_sw, dir_sw, forward_run_input, reverse_run_input, remap; // Partner requests
  logic [1:0]  sel;                    // Wanted data set
  logic [15:0] pot;                    // Pot ramp setting
  logic [15:0] sp [4];                 // Speeds per data set
  logic [31:0] seed;                   // Random state
  int          n_errors, checks;       // Counters
  ////////////////////////////////////////////////////////////////
  msrc_run_ctrl #(.DB_CYC(DB)) u_msrc_run_ctrl (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .in_pins(in_pins), .panel_run_sw(panel_run_sw),
    .panel_dir_sw(panel_dir_sw), .pot_ramp_time(pot), .speed_cmd(speed_cmd),
    .motor_dir(motor_dir), .motor_on(motor_on), .out_pins(out_pins));
  msrc_ctrl_model u_msrc_ctrl_model (.aclk(aclk), .run_sw(run_sw), .dir_sw(dir_sw),
    .forward_run_input(forward_run_input), .reverse_run_input(reverse_run_input), .sel(sel), .remap(remap), .in_pins(in_pins),
    .panel_run_sw(panel_run_sw), .panel_dir_sw(panel_dir_sw));
  ////////////////////////////////////////////////////////////////
  // Clock, 25 ns period
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // Random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Longest ramp wait: full span at the given step period
  function automatic int lim(input int r);
    return `MSRC_TICK_CYC * 17 * (r + 1) + 100;
  endfunction
  // Count and report one comparison
  task automatic chk(input bit ok, input string m);
    checks++;
    if (!ok) begin
      n_errors++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit done;
    done = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1;
      end
    end
    chk(bresp === `MSRC_RESP_OKAY, "write refused");
  endtask
  // Bus read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    chk(rdata === e && rresp === er, "read mismatch");
  endtask
  // Wait, bounded, for the commanded speed
  task automatic wspd(input logic [15:0] e, input int n);
    int c;
    c = 0;
    while (speed_cmd !== e && c < n) begin
      @(posedge aclk);
      c++;
    end
    chk(speed_cmd === e, "speed not reached");
  endtask
  // Verdict and end of run
  task automatic stop_test;
    $display("Mismatches %0d, comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Watchdog against a hung wait
  initial begin
    repeat (100000) @(posedge aclk);
    n_errors++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hF};
    {run_sw, dir_sw, forward_run_input, reverse_run_input, remap, sel, pot} = {5'h00, 2'h0, 16'h0000};
    seed = 32'h53EB;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`MSRC_A_CTRL, 32'h0, `MSRC_RESP_OKAY);
    rd(`MSRC_A_INMAP, 32'h00004688, `MSRC_RESP_OKAY);
    rd(`MSRC_A_OUTMAP, 32'h4, `MSRC_RESP_OKAY);
    rd(8'h40, 32'h0, `MSRC_RESP_SLVERR);
    // Falling random speeds; slowest set ramps prove the pot is used
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      sp[k] = 16'(13 - 4 * k) + {14'h0000, seed[1:0]};
      wr(8'(8'h10 + 8 * k), {16'h0000, sp[k]});
      wr(8'(8'h14 + 8 * k), 32'hFFFFFFFF);
    end
    wr(`MSRC_A_CTRL, 32'h1);
    run_sw <= 1'b1;
    @(posedge aclk);
    forward_run_input <= 1'b1;
    wspd(sp[0], lim(0));
    chk(motor_dir === 1'b0, "start direction");
    // Outputs register one edge after the speed settles
    @(posedge aclk);
    chk(out_pins === 2'h3, "running and at-speed outputs");
    rd(`MSRC_A_STAT, {16'h0028, sp[0]}, `MSRC_RESP_OKAY);
    for (int k = 1; k < 4; k++) begin
      sel <= 2'(k);
      wspd(sp[k], lim(0));
    end
    dir_sw <= 1'b1;
    wspd(16'h0000, lim(0));
    wspd(sp[3], lim(0));
    chk(motor_dir === 1'b1, "turn direction");
    forward_run_input <= 1'b0;
    wspd(16'h0000, lim(0));
    // External only: switch ignored, then both run inputs
    wr(`MSRC_A_CTRL, 32'h2);
    forward_run_input <= 1'b1;
    wspd(sp[3], lim(0));
    chk(motor_dir === 1'b0, "forced forward");
    reverse_run_input <= 1'b1;
    wspd(16'h0000, 20);
    forward_run_input <= 1'b0;
    reverse_run_input <= 1'b0;
    dir_sw <= 1'b0;
    wr(`MSRC_A_CTRL, 32'h1);
    forward_run_input <= 1'b1;
    wspd(sp[3], lim(0));
    run_sw <= 1'b0;
    wspd(16'h0000, lim(0));
    forward_run_input <= 1'b0;
    repeat (DB + 4) @(posedge aclk);
    // Forward run moved to pin 4
    run_sw <= 1'b1;
    remap <= 1'b1;
    wr(`MSRC_A_INMAP, 32'h0000068C);
    forward_run_input <= 1'b1;
    wspd(sp[3], lim(0));
    forward_run_input <= 1'b0;
    wspd(16'h0000, lim(0));
    // Retarget from a fast set to a slow one
    wr(`MSRC_A_CTRL, 32'h5);
    wr(8'h18, 32'h4);
    wr(8'h1C, 32'h0);
    wr(8'h20, 32'h8);
    wr(8'h24, 32'h00030003);
    sel <= 2'h1;
    forward_run_input <= 1'b1;
    wspd(16'h0004, lim(0));
    sel <= 2'h2;
    repeat (1000) @(posedge aclk);
    chk(speed_cmd <= 16'h0005 && speed_cmd >= 16'h0004, "ramp too fast");
    wspd(16'h0008, lim(3));
    forward_run_input <= 1'b0;
    wspd(16'h0000, lim(3));
    // Panel-only mode: the run switch alone starts and stops the motor
    wr(`MSRC_A_CTRL, 32'h0);
    wspd(16'h0008, lim(0));
    run_sw <= 1'b0;
    wspd(16'h0000, lim(0));
    stop_test();
  end
endmodule

/* hdl/msrc_debounce.sv */
// Two-flop synchroniser and stability filter for the run control inputs
`timescale 1ns/1ps
`include "msrc_defs.svh"
module msrc_debounce #(
  parameter int unsigned DB_CYC = `MSRC_DB_CYC
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire msrc_pkg::msrc_inputs_t raw_in,
  msrc_in_if.src                      clean
);
  msrc_pkg::msrc_inputs_t sync1_r; // First stage, read only by sync2_r
  msrc_pkg::msrc_inputs_t sync2_r; // Second stage, safe to use
  msrc_pkg::msrc_inputs_t cand_r;  // Candidate value being timed
  msrc_pkg::msrc_inputs_t level_r; // Accepted value
  logic [19:0]            cnt_r;   // Cycles the candidate has held

  ////////////////////////////////////////////////////////////////////////
  // Synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stability timer: one shared timer, any bit change restarts it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cand_r <= '0;
      cnt_r  <= '0;
    end else if (sync2_r != cand_r) begin
      cand_r <= sync2_r;
      cnt_r  <= '0;
    end else if (cnt_r < 20'(DB_CYC - 1)) begin
      cnt_r <= cnt_r + 20'h00001;
    end
  end

  // Commit once stable for the full time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_r <= '0;
    end else if (sync2_r == cand_r && cnt_r == 20'(DB_CYC - 1)) begin
      level_r <= cand_r;
    end
  end

  assign clean.level = level_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_db_stable_commit: assert property (@(posedge aclk) disable iff (!aresetn)
    (level_r != $past(level_r)) |-> ($past(cnt_r) == 20'(DB_CYC - 1)))
    else $error("filtered input changed before stable time");
endmodule

/* hdl/msrc_defs.svh */
// Constants for the multi-speed run control block: map, fields, resets, timing
`ifndef MSRC_DEFS_SVH
`define MSRC_DEFS_SVH
// Register byte addresses
`define MSRC_A_CTRL      8'h00
`define MSRC_A_INMAP     8'h04
`define MSRC_A_OUTMAP    8'h08
`define MSRC_A_POT       8'h0C
`define MSRC_A_SET_BASE  8'h10
`define MSRC_A_SET_LAST  8'h2C
`define MSRC_A_STAT      8'h30
`define MSRC_SET_IDX_OFS 3'h2
// External-operation mode field in CTRL[1:0], ramp source in CTRL[2]
`define MSRC_EXT_OFF     2'h0
`define MSRC_EXT_ON      2'h1
`define MSRC_EXT_ONLY    2'h2
`define MSRC_CTRL_DIG    2
`define MSRC_CTRL_RST    3'h0
// Input function codes, one 3-bit field per input pin
`define MSRC_FN_FWD      3'h0
`define MSRC_FN_REV      3'h1
`define MSRC_FN_SEL_LO   3'h2
`define MSRC_FN_SEL_HI   3'h3
`define MSRC_INMAP_RST   15'h4688
// Output function codes, one 2-bit field per output pin
`define MSRC_OF_RUNNING  2'h0
`define MSRC_OF_AT_SPEED 2'h1
`define MSRC_OF_DIR      2'h2
`define MSRC_OF_STOPPED  2'h3
`define MSRC_OUTMAP_RST  4'h4
// Data set speed and ramp resets
`define MSRC_SPEED_RST   16'h0000
`define MSRC_RAMP_RST    16'h0000
// Debounced input vector positions
`define MSRC_IX_RUN_SW   5
`define MSRC_IX_DIR_SW   6
// Bus responses
`define MSRC_RESP_OKAY   2'h0
`define MSRC_RESP_SLVERR 2'h2
// Timing
`define MSRC_CLK_HZ      40000000
`define MSRC_TICK_NS     10000
`define MSRC_TICK_CYC    ((`MSRC_CLK_HZ / 1000000) * `MSRC_TICK_NS / 1000)
`define MSRC_DB_US       1000
`define MSRC_DB_CYC      ((`MSRC_CLK_HZ / 1000000) * `MSRC_DB_US)
`endif

/* hdl/msrc_in_if.sv */
// Carrier of the debounced input levels between filter and sequencer
`timescale 1ns/1ps
interface msrc_in_if;
  msrc_pkg::msrc_inputs_t level; // Filtered levels, high = on
  modport src (output level);
  modport dst (input level);
endinterface

/* hdl/msrc_pkg.sv */
// Types shared by the multi-speed run control block
package msrc_pkg;
  // Run sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_STOP,
    ST_TURN
  } msrc_state_t;
  // Debounced input vector: five mapped pins, run switch, direction switch
  typedef logic [6:0] msrc_inputs_t;
endpackage

/* hdl/msrc_run_ctrl.sv */
// Multi-speed run control: data set select, ramps, start/stop, direction
// Notes on behaviour
// - Two select inputs pick data set 0-3
// - Running uses selected set's speed and ramps
// - After reset ramp times come from pot
// - Run input starts motor when externally enabled
// - Starting input released brings ramped stop
// - Select change while running retargets speed
// - Retarget ramps with the new set's times
// - Start direction follows the direction switch
// - Direction change decelerates, stops, then restarts
// - External-only mode forces forward direction
// - Five inputs and two outputs are remappable
// - Both run inputs on stops motor instantly
// - Panel stand-by decelerates to stop anyway; not in external-only mode, where the run switch is ignored
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "msrc_defs.svh"
module msrc_run_ctrl #(
  parameter int unsigned DB_CYC = `MSRC_DB_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output wire logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output wire logic        wready,
  output wire logic [1:0]  bresp,
  output wire logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output wire logic        arready,
  output wire logic [31:0] rdata,
  output wire logic [1:0]  rresp,
  output wire logic        rvalid,
  input  wire logic        rready,
  input  wire logic [4:0]  in_pins,
  input  wire logic        panel_run_sw,
  input  wire logic        panel_dir_sw,
  input  wire logic [15:0] pot_ramp_time,
  output wire logic [15:0] speed_cmd,
  output wire logic        motor_dir,
  output wire logic        motor_on,
  output wire logic [1:0]  out_pins
);
  ////////////////////////////////////////////////////////////////////////
  // Helpers
  // Any pin whose field holds this function code and is on
  function automatic logic fn_on(input logic [14:0] map, input logic [4:0] pins,
                                 input logic [2:0] code);
    fn_on = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (map[3*i +: 3] == code && pins[i]) begin
        fn_on = 1'b1;
      end
    end
  endfunction
  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction
  // Data set index of a set address
  function automatic logic [1:0] set_idx(input logic [7:0] a);
    set_idx = 2'(a[5:3] - `MSRC_SET_IDX_OFS);
  endfunction
  // True for a mapped, word-aligned address
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= `MSRC_A_STAT);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Input filter
  msrc_in_if in_bus ();
  msrc_debounce #(.DB_CYC(DB_CYC)) u_filt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .raw_in  ({panel_dir_sw, panel_run_sw, in_pins}),
    .clean   (in_bus.src)
  );

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [2:0]  ctrl_r;          // Mode [1:0], digital ramp [2]
  logic [14:0] inmap_r;         // Input function per pin
  logic [3:0]  outmap_r;        // Output function per pin
  logic [15:0] speed_set_r [4]; // Target speed per set, r/min
  logic [15:0] acc_set_r [4];   // Accel step period per set, ticks
  logic [15:0] dec_set_r [4];   // Decel step period per set, ticks
  // Bus state
  logic        aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r, rdata_r, rd_word;
  logic [3:0]  wstrb_r;
  logic [1:0]  bresp_r, rresp_r;
  logic        wr_fire;
  // Run state
  msrc_pkg::msrc_state_t state_r;
  logic [15:0] speed_r;         // Present commanded speed
  logic [15:0] step_cnt_r;      // Ticks since last speed step
  logic [8:0]  tick_cnt_r;      // Divider for the ramp tick
  logic        tick;            // One-cycle ramp tick
  logic        dir_r;           // 1 = reverse
  logic        src_rev_r;       // Run input that started the motor
  logic [1:0]  out_r;
  // Decoded commands, declared early so the status read can see them
  logic [4:0]  pins;
  logic        forward_run_input, reverse_run_input, both, ext, ext_only, panel_ok, run_req, held, dir_want;
  logic [1:0]  sel;
  logic [15:0] target, acc_t, dec_t, goal, rate;

  ////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order, one at a time
  assign awready = !aw_hold_r && !bvalid_r;
  assign wready  = !w_hold_r && !bvalid_r;
  assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `MSRC_RESP_OKAY;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= addr_ok(awaddr_r) && awaddr_r != `MSRC_A_STAT ?
                     `MSRC_RESP_OKAY : `MSRC_RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Register store; the status word is read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= `MSRC_CTRL_RST;
      inmap_r  <= `MSRC_INMAP_RST;
      outmap_r <= `MSRC_OUTMAP_RST;
      for (int i = 0; i < 4; i++) begin
        speed_set_r[i] <= `MSRC_SPEED_RST;
        acc_set_r[i]   <= `MSRC_RAMP_RST;
        dec_set_r[i]   <= `MSRC_RAMP_RST;
      end
    end else if (wr_fire) begin
      if (awaddr_r == `MSRC_A_CTRL) begin
        ctrl_r <= 3'(merge({29'h0, ctrl_r}, wdata_r, wstrb_r));
      end else if (awaddr_r == `MSRC_A_INMAP) begin
        inmap_r <= 15'(merge({17'h0, inmap_r}, wdata_r, wstrb_r));
      end else if (awaddr_r == `MSRC_A_OUTMAP) begin
        outmap_r <= 4'(merge({28'h0, outmap_r}, wdata_r, wstrb_r));
      end else if (awaddr_r >= `MSRC_A_SET_BASE && awaddr_r <= `MSRC_A_SET_LAST
                   && awaddr_r[1:0] == 2'h0) begin
        if (!awaddr_r[2]) begin
          speed_set_r[set_idx(awaddr_r)] <=
            16'(merge({16'h0, speed_set_r[set_idx(awaddr_r)]}, wdata_r, wstrb_r));
        end else begin
          {dec_set_r[set_idx(awaddr_r)], acc_set_r[set_idx(awaddr_r)]} <=
            merge({dec_set_r[set_idx(awaddr_r)], acc_set_r[set_idx(awaddr_r)]},
                  wdata_r, wstrb_r);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel: one read at a time, answer one cycle after address
  assign arready = !rvalid_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;
  always_comb begin
    rd_word = 32'h00000000;
    if (araddr == `MSRC_A_CTRL) begin
      rd_word = {29'h0, ctrl_r};
    end else if (araddr == `MSRC_A_INMAP) begin
      rd_word = {17'h0, inmap_r};
    end else if (araddr == `MSRC_A_OUTMAP) begin
      rd_word = {28'h0, outmap_r};
    end else if (araddr == `MSRC_A_POT) begin
      rd_word = {16'h0, pot_ramp_time};
    end else if (araddr >= `MSRC_A_SET_BASE && araddr <= `MSRC_A_SET_LAST
                 && araddr[1:0] == 2'h0) begin
      rd_word = araddr[2] ? {dec_set_r[set_idx(araddr)], acc_set_r[set_idx(araddr)]}
                          : {16'h0, speed_set_r[set_idx(araddr)]};
    end else if (araddr == `MSRC_A_STAT) begin
      // Live state: speed, selected set, direction, sequencer state
      rd_word = {10'h0, motor_on, 2'(state_r), dir_r, sel, speed_r};
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= `MSRC_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= addr_ok(araddr) ? `MSRC_RESP_OKAY : `MSRC_RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decode from filtered inputs
  assign pins     = in_bus.level[4:0];
  assign forward_run_input      = fn_on(inmap_r, pins, `MSRC_FN_FWD);
  assign reverse_run_input      = fn_on(inmap_r, pins, `MSRC_FN_REV);
  assign sel      = {fn_on(inmap_r, pins, `MSRC_FN_SEL_HI),
                     fn_on(inmap_r, pins, `MSRC_FN_SEL_LO)};
  assign ext_only = ctrl_r[1:0] == `MSRC_EXT_ONLY;
  assign ext      = ctrl_r[1:0] == `MSRC_EXT_ON || ext_only;
  // Panel run switch is honoured unless the panel is disabled
  assign panel_ok = ext_only || in_bus.level[`MSRC_IX_RUN_SW];
  assign both     = ext && forward_run_input && reverse_run_input;
  assign run_req  = ext ? ((forward_run_input ^ reverse_run_input) && panel_ok) : panel_ok;
  assign held     = ext ? (src_rev_r ? reverse_run_input : forward_run_input) : panel_ok;
  assign dir_want = ext_only ? 1'b0 : in_bus.level[`MSRC_IX_DIR_SW];
  // Live set lookup, so a select change retargets at once
  assign target   = speed_set_r[sel];
  assign acc_t    = ctrl_r[`MSRC_CTRL_DIG] ? acc_set_r[sel] : pot_ramp_time;
  assign dec_t    = ctrl_r[`MSRC_CTRL_DIG] ? dec_set_r[sel] : pot_ramp_time;
  assign goal     = state_r == msrc_pkg::ST_RUN ? target : 16'h0000;
  assign rate     = goal > speed_r ? acc_t : dec_t;

  ////////////////////////////////////////////////////////////////////////
  // Run sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r   <= msrc_pkg::ST_IDLE;
      dir_r     <= 1'b0;
      src_rev_r <= 1'b0;
    end else if (both) begin
      state_r <= msrc_pkg::ST_IDLE;
    end else begin
      case (state_r)
        msrc_pkg::ST_IDLE: begin
          if (run_req) begin
            state_r   <= msrc_pkg::ST_RUN;
            dir_r     <= dir_want;
            src_rev_r <= reverse_run_input;
          end
        end
        msrc_pkg::ST_RUN: begin
          if (!held || !panel_ok) begin
            state_r <= msrc_pkg::ST_STOP;
          end else if (dir_want != dir_r) begin
            state_r <= msrc_pkg::ST_TURN;
          end
        end
        msrc_pkg::ST_STOP: begin
          if (speed_r == 16'h0000) begin
            state_r <= msrc_pkg::ST_IDLE;
          end
        end
        default: begin
          // Reversal: coast down on the ramp, then restart the other way
          if (!held || !panel_ok) begin
            state_r <= msrc_pkg::ST_STOP;
          end else if (speed_r == 16'h0000) begin
            state_r <= msrc_pkg::ST_RUN;
            dir_r   <= dir_want;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ramp tick divider
  assign tick = tick_cnt_r == 9'(`MSRC_TICK_CYC - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      tick_cnt_r <= 9'h000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 9'h001;
    end
  end

  // Speed ramp: one r/min per step, step every rate+1 ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_r    <= 16'h0000;
      step_cnt_r <= 16'h0000;
    end else if (both) begin
      speed_r    <= 16'h0000;
      step_cnt_r <= 16'h0000;
    end else if (tick) begin
      if (speed_r == goal) begin
        step_cnt_r <= 16'h0000;
      end else if (step_cnt_r >= rate) begin
        speed_r    <= goal > speed_r ? speed_r + 16'h0001 : speed_r - 16'h0001;
        step_cnt_r <= 16'h0000;
      end else begin
        step_cnt_r <= step_cnt_r + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Remappable outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_r <= 2'h0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        case (outmap_r[2*k +: 2])
          `MSRC_OF_RUNNING:  out_r[k] <= state_r != msrc_pkg::ST_IDLE;
          `MSRC_OF_AT_SPEED: out_r[k] <= state_r == msrc_pkg::ST_RUN && speed_r == target;
          `MSRC_OF_DIR:      out_r[k] <= dir_r;
          default:           out_r[k] <= speed_r == 16'h0000;
        endcase
      end
    end
  end
  assign out_pins  = out_r;
  assign speed_cmd = speed_r;
  assign motor_dir = dir_r;
  assign motor_on  = state_r != msrc_pkg::ST_IDLE;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_sel_from_pins: assert property ((inmap_r == `MSRC_INMAP_RST) |->
    (sel == pins[3:2]))
    else $error("set not chosen by the select pins");
  a_ramp_up_step: assert property ((state_r == msrc_pkg::ST_RUN && !both && tick
    && speed_r < target && step_cnt_r >= acc_t) |=> speed_r == $past(speed_r) + 16'h0001)
    else $error("accel step missing");
  a_pot_default: assert property (!ctrl_r[`MSRC_CTRL_DIG] |-> rate == pot_ramp_time)
    else $error("pot ramp time not in use");
  a_start_run: assert property ((state_r == msrc_pkg::ST_IDLE && run_req && !both)
    |=> state_r == msrc_pkg::ST_RUN)
    else $error("run input did not start motor");
  a_release_stop: assert property ((state_r == msrc_pkg::ST_RUN && !held && !both)
    |=> state_r == msrc_pkg::ST_STOP ##1 (state_r != msrc_pkg::ST_RUN))
    else $error("release did not stop motor");
  a_new_set_rate: assert property ((ctrl_r[`MSRC_CTRL_DIG] && goal < speed_r)
    |-> rate == dec_set_r[sel])
    else $error("ramp not from selected set");
  a_start_dir: assert property ((state_r == msrc_pkg::ST_IDLE ##1
    state_r == msrc_pkg::ST_RUN) |-> dir_r == $past(dir_want))
    else $error("start direction wrong");
  a_turn_decel: assert property ((state_r == msrc_pkg::ST_RUN && held && panel_ok
    && !both && dir_want != dir_r) |=> state_r == msrc_pkg::ST_TURN && dir_r == $past(dir_r))
    else $error("direction change not decelerated");
  a_ext_only_fwd: assert property ((ext_only && state_r == msrc_pkg::ST_IDLE && run_req
    && !both) |=> !dir_r)
    else $error("external-only start not forward");
  a_both_halt: assert property (both |=> speed_r == 16'h0000 && !motor_on)
    else $error("both inputs did not stop instantly");
  a_standby_stop: assert property ((state_r == msrc_pkg::ST_RUN && ext && !ext_only
    && !in_bus.level[`MSRC_IX_RUN_SW] && !both) |=> state_r == msrc_pkg::ST_STOP)
    else $error("stand-by ignored");
  c_start: cover property (state_r == msrc_pkg::ST_IDLE ##1 state_r == msrc_pkg::ST_RUN);
  c_turn: cover property (state_r == msrc_pkg::ST_TURN ##1 state_r == msrc_pkg::ST_RUN);
  c_halt: cover property (both && speed_r != 16'h0000);
  c_reselect: cover property (state_r == msrc_pkg::ST_RUN && sel != $past(sel));
endmodule
